/* File: rtl/fspc_pkg.sv */
package fspc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_KEY       = 8'h04;
  localparam logic [7:0] REG_ADR_LO    = 8'h08;
  localparam logic [7:0] REG_ADR_HI    = 8'h0c;
  localparam logic [7:0] REG_LATCH_IDX = 8'h10;
  localparam logic [7:0] REG_LATCH_DAT = 8'h14;
  localparam int unsigned CTRL_WR_BIT   = 15;
  localparam int unsigned CTRL_PROGRAM_ENABLE_BIT_BIT = 14;
  localparam int unsigned CTRL_ERR_BIT  = 13;
  localparam int unsigned CTRL_SIDL_BIT = 12;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'haa;
  localparam logic [3:0]  OP_DWORD      = 4'h1;
  localparam logic [3:0]  OP_ROW        = 4'h2;
  localparam logic [3:0]  OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0]  OP_UNUSED     = 4'h4;
  localparam logic [3:0]  OP_CHIP_ERASE = 4'he;
  localparam int unsigned ROW_WORDS     = 128;
  localparam int unsigned DWORD_WORDS   = 2;
  localparam logic [23:0] ROW_MASK      = 24'hffff00;
  localparam logic [23:0] BLOCK_MASK    = 24'hfff800;
  localparam logic [23:0] DWORD_MASK    = 24'hfffffc;
  localparam logic [23:0] CHIP_ADDR     = 24'h000000;
  localparam int unsigned T_DWORD_NS    = 20000;
  localparam int unsigned T_ROW_NS      = 100000;
  localparam int unsigned T_PAGE_NS     = 160000;
  localparam int unsigned T_CHIP_NS     = 160000;
  localparam logic [12:0] DWORD_CYC = 13'((T_DWORD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [12:0] ROW_CYC   = 13'((T_ROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [12:0] PAGE_CYC  = 13'((T_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [12:0] CHIP_CYC  = 13'((T_CHIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    KEY_IDLE  = 3'b001,
    KEY_HALF  = 3'b010,
    KEY_ARMED = 3'b100
  } fspc_key_e;
  typedef enum logic [2:0] {
    OPS_IDLE = 3'b001,
    OPS_XFER = 3'b010,
    OPS_WAIT = 3'b100
  } fspc_ops_e;
endpackage

/* File: rtl/fspc_latch_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module fspc_latch_mem #(
  parameter int unsigned WORDS = 128,
  parameter int unsigned WIDTH = 24
) (
  input  wire logic                     clk_in,
  input  wire logic                     ce_in,
  input  wire logic                     we_in,
  input  wire logic [$clog2(WORDS)-1:0] waddr_in,
  input  wire logic [WIDTH-1:0]         wdata_in,
  input  wire logic [$clog2(WORDS)-1:0] raddr_in,
  output logic      [WIDTH-1:0]         rdata_out
);
  logic [WIDTH-1:0] mem_q [WORDS];

  // holding latches, no reset
  always_ff @(posedge clk_in) begin
    if (ce_in && we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      rdata_out <= mem_q[raddr_in];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/fspc_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module fspc_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        load_in,
  input  wire logic [12:0] cycles_in,
  output logic             done_out
);
  logic [12:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 13'h0000;
    end else if (ce_in) begin
      if (load_in) begin
        cnt_q <= cycles_in;
      end else if (cnt_q != 13'h0000) begin
        cnt_q <= cnt_q - 13'h0001;
      end
    end
  end

  assign done_out = ce_in && !load_in && (cnt_q == 13'h0001);
endmodule
`default_nettype wire

/* File: rtl/fspc_ctrl.sv */
// Operation
// - rows of 128 words, block and dword ops
// - row and block addresses aligned, low bits ignored
// - table writes land in holding latches
// - any number of latch writes programs fine
// - latches rewritable in any order, last wins
// - single-word latch writes, one cycle per word
// - write-only key, 55h then AAh required
// - address from register pair, chip erase fixed
// - processor stalled while operation runs
// - start bit 15 launches, cleared when done
// - start bit set by software, hardware clears
// - enable bit 14 gates program and erase
// - error flag bit 13 on improper sequence
// - bit 12 selects power-down or standby in idle
// - operation field decodes four codes at 3:0
// - control fields reset only at power-on
// - bits 11:10 reserved, 9:4 read zero
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter int unsigned LATCH_WORDS = 128
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        idle_in,
  output logic             cpu_stall_out,
  output logic             flash_start_out,
  output logic [3:0]       flash_op_out,
  output logic [23:0]      flash_addr_out,
  output logic             flash_word_we_out,
  output logic [23:0]      flash_word_addr_out,
  output logic [23:0]      flash_word_data_out,
  output logic             flash_power_down_out,
  output logic             flash_standby_out
);
  localparam int unsigned IW = $clog2(LATCH_WORDS);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic op_ok(input logic [3:0] op);
    return (op == OP_DWORD) || (op == OP_ROW) || (op == OP_PAGE_ERASE) ||
           (op == OP_CHIP_ERASE);
  endfunction

  function automatic logic op_is_prog(input logic [3:0] op);
    return (op == OP_DWORD) || (op == OP_ROW);
  endfunction

  logic            aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [7:0]      awaddr_q;
  logic [31:0]     wdata_q, rdata_q, rd_val, new_val;
  logic [3:0]      wstrb_q;
  logic [1:0]      bresp_q, rresp_q;
  logic            do_wr, rd_hit, wr_hit;
  logic            wr_q, program_enable_bit_q, err_q, sidl_q;
  logic [3:0]      op_q;
  logic [15:0]     ctrl_rd;
  logic [15:0]     adr_lo_q;
  logic [7:0]      adr_hi_q;
  logic [IW-1:0]   lidx_q;
  fspc_key_e       key_q;
  fspc_ops_e       ops_q;
  logic            set_try, go, bad, op_done, tmr_done, tmr_load;
  logic [3:0]      run_op_q;
  logic [23:0]     base_q, dest;
  logic [IW-1:0]   idx_q, idx1_q, last_idx;
  logic            vld1_q;
  logic [23:0]     mem_rdata;
  logic [12:0]     op_cyc;

  assign ctrl_rd = {wr_q, program_enable_bit_q, err_q, sidl_q, 8'h00, op_q};
  assign dest    = {adr_hi_q, adr_lo_q};

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr_in == REG_CTRL) begin
      rd_val = {16'h0000, ctrl_rd};
    end else if (s_axi_araddr_in == REG_KEY) begin
      rd_val = 32'h0000_0000;
    end else if (s_axi_araddr_in == REG_ADR_LO) begin
      rd_val = {16'h0000, adr_lo_q};
    end else if (s_axi_araddr_in == REG_ADR_HI) begin
      rd_val = {24'h000000, adr_hi_q};
    end else if (s_axi_araddr_in == REG_LATCH_IDX) begin
      rd_val = 32'(lidx_q);
    end else if (s_axi_araddr_in == REG_LATCH_DAT) begin
      rd_val = 32'h0000_0000;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (awaddr_q == REG_CTRL) begin
      new_val = merge({16'h0000, ctrl_rd}, wdata_q, wstrb_q);
    end else if (awaddr_q == REG_ADR_LO) begin
      new_val = merge({16'h0000, adr_lo_q}, wdata_q, wstrb_q);
    end else if (awaddr_q == REG_ADR_HI) begin
      new_val = merge({24'h000000, adr_hi_q}, wdata_q, wstrb_q);
    end else if (awaddr_q == REG_LATCH_IDX) begin
      new_val = merge(32'(lidx_q), wdata_q, wstrb_q);
    end else if (awaddr_q == REG_KEY || awaddr_q == REG_LATCH_DAT) begin
      new_val = merge(32'h0000_0000, wdata_q, wstrb_q);
    end else begin
      new_val = 32'h0000_0000;
      wr_hit  = 1'b0;
    end
  end

  assign s_axi_awready_out = ce_in && !aw_full_q && (ops_q == OPS_IDLE);
  assign s_axi_wready_out  = ce_in && !w_full_q && (ops_q == OPS_IDLE);
  assign s_axi_arready_out = ce_in && !rvalid_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata_in;
        wstrb_q  <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_val;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // two-key unlock, any other write cancels
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      key_q <= KEY_IDLE;
    end else if (ce_in && do_wr) begin
      if (awaddr_q == REG_KEY && new_val[7:0] == KEY_FIRST) begin
        key_q <= KEY_HALF;
      end else begin
        case (key_q)
          KEY_HALF: begin
            key_q <= (awaddr_q == REG_KEY && new_val[7:0] == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
          end
          default: begin
            key_q <= KEY_IDLE;
          end
        endcase
      end
    end
  end

  assign set_try = do_wr && (awaddr_q == REG_CTRL) && new_val[CTRL_WR_BIT] && !wr_q;
  // enable bit gates launch, implemented codes only
  assign go  = set_try && (key_q == KEY_ARMED) && new_val[CTRL_PROGRAM_ENABLE_BIT_BIT] && op_ok(new_val[3:0]);
  assign bad = set_try && !go;

  // control fields written by CTRL writes, reset only by power-on reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      program_enable_bit_q <= CTRL_RESET[CTRL_PROGRAM_ENABLE_BIT_BIT];
      sidl_q <= CTRL_RESET[CTRL_SIDL_BIT];
      op_q   <= CTRL_RESET[3:0];
    end else if (ce_in && do_wr && awaddr_q == REG_CTRL) begin
      program_enable_bit_q <= new_val[CTRL_PROGRAM_ENABLE_BIT_BIT];
      sidl_q <= new_val[CTRL_SIDL_BIT];
      op_q   <= new_val[3:0];
    end
  end

  // start launches, cleared at end; only hardware clears
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_q <= CTRL_RESET[CTRL_WR_BIT];
    end else if (ce_in) begin
      if (go) begin
        wr_q <= 1'b1;
      end else if (op_done) begin
        wr_q <= 1'b0;
      end
    end
  end

  // error set on improper attempt, cleared by good launch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      err_q <= CTRL_RESET[CTRL_ERR_BIT];
    end else if (ce_in) begin
      if (bad) begin
        err_q <= 1'b1;
      end else if (go) begin
        err_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adr_lo_q <= 16'h0000;
      adr_hi_q <= 8'h00;
      lidx_q   <= '0;
    end else if (ce_in && do_wr) begin
      if (awaddr_q == REG_ADR_LO) begin
        adr_lo_q <= new_val[15:0];
      end else if (awaddr_q == REG_ADR_HI) begin
        adr_hi_q <= new_val[7:0];
      end else if (awaddr_q == REG_LATCH_IDX) begin
        lidx_q <= new_val[IW-1:0];
      end
    end
  end

  // table writes only fill latches; last write wins
  fspc_latch_mem #(
    .WORDS (LATCH_WORDS),
    .WIDTH (24)
  ) u_latch (
    .clk_in    (clk_in),
    .ce_in     (ce_in),
    .we_in     (do_wr && awaddr_q == REG_LATCH_DAT),
    .waddr_in  (lidx_q),
    .wdata_in  (new_val[23:0]),
    .raddr_in  (idx_q),
    .rdata_out (mem_rdata)
  );

  always_comb begin
    if (run_op_q == OP_DWORD) begin
      op_cyc   = DWORD_CYC;
      last_idx = IW'(DWORD_WORDS - 1);
    end else if (run_op_q == OP_ROW) begin
      op_cyc   = ROW_CYC;
      last_idx = IW'(ROW_WORDS - 1);
    end else if (run_op_q == OP_PAGE_ERASE) begin
      op_cyc   = PAGE_CYC;
      last_idx = '0;
    end else begin
      op_cyc   = CHIP_CYC;
      last_idx = '0;
    end
  end

  assign tmr_load = (ops_q == OPS_XFER) && (idx_q == last_idx);
  assign op_done  = (ops_q == OPS_WAIT) && tmr_done;

  // streams 2 latch words for dword, 128 for row, one cycle per word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ops_q    <= OPS_IDLE;
      idx_q    <= '0;
      run_op_q <= OP_DWORD;
    end else if (ce_in) begin
      case (ops_q)
        OPS_IDLE: begin
          idx_q <= '0;
          if (go) begin
            run_op_q <= new_val[3:0];
            ops_q    <= OPS_XFER;
          end
        end
        OPS_XFER: begin
          if (idx_q == last_idx) begin
            ops_q <= OPS_WAIT;
          end else begin
            idx_q <= idx_q + IW'(1);
          end
        end
        OPS_WAIT: begin
          if (tmr_done) begin
            ops_q <= OPS_IDLE;
          end
        end
        default: begin
          ops_q <= OPS_IDLE;
        end
      endcase
    end
  end

  fspc_timer u_timer (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .load_in   (tmr_load),
    .cycles_in (op_cyc),
    .done_out  (tmr_done)
  );

  // row, block, dword spans; aligned base; chip fixed
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flash_start_out <= 1'b0;
      flash_op_out    <= 4'h0;
      flash_addr_out  <= 24'h000000;
      base_q          <= 24'h000000;
    end else if (ce_in) begin
      flash_start_out <= go;
      if (go) begin
        flash_op_out <= new_val[3:0];
        if (new_val[3:0] == OP_ROW) begin
          base_q         <= dest & ROW_MASK;
          flash_addr_out <= dest & ROW_MASK;
        end else if (new_val[3:0] == OP_PAGE_ERASE) begin
          base_q         <= dest & BLOCK_MASK;
          flash_addr_out <= dest & BLOCK_MASK;
        end else if (new_val[3:0] == OP_DWORD) begin
          base_q         <= dest & DWORD_MASK;
          flash_addr_out <= dest & DWORD_MASK;
        end else begin
          base_q         <= CHIP_ADDR;
          flash_addr_out <= CHIP_ADDR;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vld1_q              <= 1'b0;
      idx1_q              <= '0;
      flash_word_we_out   <= 1'b0;
      flash_word_addr_out <= 24'h000000;
      flash_word_data_out <= 24'h000000;
    end else if (ce_in) begin
      vld1_q            <= (ops_q == OPS_XFER) && op_is_prog(run_op_q);
      idx1_q            <= idx_q;
      flash_word_we_out <= vld1_q;
      if (vld1_q) begin
        flash_word_addr_out <= base_q + 24'({idx1_q, 1'b0});
        flash_word_data_out <= mem_rdata;
      end
    end
  end

  assign cpu_stall_out = (ops_q != OPS_IDLE);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flash_power_down_out <= 1'b0;
      flash_standby_out    <= 1'b0;
    end else if (ce_in) begin
      flash_power_down_out <= idle_in && sidl_q;
      flash_standby_out    <= idle_in && !sidl_q;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  start_needs_key_a: assert property (ce_in && set_try && key_q != KEY_ARMED
                                      |=> err_q && !wr_q)
    else $error("start without unlock not flagged");
  start_clears_done_a: assert property (ce_in && op_done |=> !wr_q && ops_q == OPS_IDLE)
    else $error("start bit not cleared at end");
  start_held_a: assert property (wr_q && !(ce_in && op_done) |=> wr_q)
    else $error("start bit dropped early");
  stall_while_busy_a: assert property (wr_q |-> cpu_stall_out)
    else $error("cpu not stalled during operation");
  launch_needs_program_enable_bit_a: assert property (go |=> program_enable_bit_q && flash_start_out)
    else $error("launch without enable");
  reserved_bits_zero_a: assert property (s_axi_arvalid_in && s_axi_arready_out
                                         && s_axi_araddr_in == REG_CTRL
                                         |=> s_axi_rdata_out[11:4] == 8'h00)
    else $error("reserved control bits nonzero");
  armed_after_keys_a: assert property (ce_in && key_q == KEY_HALF && do_wr && awaddr_q == REG_KEY
                                       && new_val[7:0] == KEY_SECOND |=> key_q == KEY_ARMED)
    else $error("unlock not armed by second key");
  row_addr_aligned_a: assert property (flash_start_out && flash_op_out == OP_ROW
                                       |-> (flash_addr_out & ~ROW_MASK) == 24'h000000)
    else $error("row address not aligned");
  chip_addr_fixed_a: assert property (flash_start_out && flash_op_out == OP_CHIP_ERASE
                                      |-> flash_addr_out == CHIP_ADDR)
    else $error("chip erase address not fixed");
  idle_power_a: assert property (ce_in && idle_in && sidl_q |=> flash_power_down_out
                                 && !flash_standby_out)
    else $error("idle power-down not applied");
endmodule
`default_nettype wire

/* File: dv/fspc_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fspc_flash_model (
  input  wire logic        clk_in,
  input  wire logic        start_in,
  input  wire logic [3:0]  op_in,
  input  wire logic [23:0] addr_in,
  input  wire logic        we_in,
  input  wire logic [23:0] waddr_in,
  input  wire logic [23:0] wdata_in,
  output logic      [7:0]  starts_out,
  output logic      [3:0]  op_out,
  output logic      [23:0] addr_out,
  output logic      [8:0]  words_out,
  output logic      [23:0] first_out,
  output logic      [23:0] last_out,
  output logic      [23:0] last_addr_out
);
  initial starts_out = 8'h00;
  // array takes one operation and its words
  always @(posedge clk_in) begin
    if (start_in) begin
      starts_out <= starts_out + 8'h01;
      op_out <= op_in;
      addr_out <= addr_in;
      words_out <= 9'h000;
    end else if (we_in) begin
      if (words_out == 9'h000) begin
        first_out <= wdata_in;
      end
      words_out <= words_out + 9'h001;
      last_out <= wdata_in;
      last_addr_out <= waddr_in;
    end
  end
endmodule
`default_nettype wire

/* File: dv/fspc_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module fspc_ctrl_tb;
  import fspc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic idle = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, stall, fstart, fwe, pd, sb;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0] br, rr;
  logic [3:0] fop, mop;
  logic [23:0] faddr, fwa, fwd, maddr, mfirst, mlast, mla;
  logic [7:0] starts;
  logic [8:0] words;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 clk_in = ~clk_in;
  fspc_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .idle_in(idle),
    .cpu_stall_out(stall), .flash_start_out(fstart), .flash_op_out(fop),
    .flash_addr_out(faddr), .flash_word_we_out(fwe), .flash_word_addr_out(fwa),
    .flash_word_data_out(fwd), .flash_power_down_out(pd), .flash_standby_out(sb));
  fspc_flash_model flash (.clk_in(clk_in), .start_in(fstart), .op_in(fop),
    .addr_in(faddr), .we_in(fwe), .waddr_in(fwa), .wdata_in(fwd), .starts_out(starts),
    .op_out(mop), .addr_out(maddr), .words_out(words), .first_out(mfirst),
    .last_out(mlast), .last_addr_out(mla));
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic da;
    logic dw;
    da = 1'b0;
    dw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk_in);
      da = da | (awvalid & awready);
      dw = dw | (wvalid & wready);
      @(posedge clk_in);
      if (da) awvalid <= 1'b0;
      if (dw) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    @(negedge clk_in);
    while (bvalid !== 1'b1) @(negedge clk_in);
    br = bresp;
    @(posedge clk_in);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge clk_in);
    while (arready !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    arvalid <= 1'b0;
    rready <= 1'b1;
    @(negedge clk_in);
    while (rvalid !== 1'b1) @(negedge clk_in);
    rd = rdata;
    rr = rresp;
    @(posedge clk_in);
    rready <= 1'b0;
  endtask
  task automatic latch(input logic [6:0] i, input logic [23:0] d);
    axw(REG_LATCH_IDX, {25'h0000000, i});
    axw(REG_LATCH_DAT, {8'h00, d});
  endtask
  task automatic launch(input logic [3:0] op, input logic [23:0] a, input logic [23:0] ea,
                        input logic [8:0] n);
    axw(REG_ADR_LO, {16'h0000, a[15:0]});
    axw(REG_ADR_HI, {24'h000000, a[23:16]});
    axw(REG_CTRL, {20'h00004, 8'h00, op});
    axw(REG_KEY, {24'h000000, KEY_FIRST});
    axw(REG_KEY, {24'h000000, KEY_SECOND});
    axw(REG_CTRL, {20'h0000c, 8'h00, op});
    chk(32'(stall), 32'h00000001, "stall");
    axr(REG_CTRL);
    chk(rd, {20'h0000c, 8'h00, op}, "ctrl busy");
    while (stall !== 1'b0) @(negedge clk_in);
    @(posedge clk_in);
    axr(REG_CTRL);
    chk(rd, {20'h00004, 8'h00, op}, "ctrl done");
    chk(32'(mop), 32'(op), "op");
    chk(32'(maddr), 32'(ea), "addr");
    chk(32'(words), 32'(n), "words");
    $display("test op %h done", op);
  endtask
  task automatic bad(input int mode, input logic [15:0] c);
    logic [7:0] s0;
    s0 = starts;
    if (mode > 0) axw(REG_KEY, {24'h000000, KEY_FIRST});
    if (mode == 2) axw(REG_ADR_LO, 32'h00000000);
    if (mode > 0) axw(REG_KEY, {24'h000000, KEY_SECOND});
    if (mode == 3) axw(REG_ADR_LO, 32'h00000000);
    axw(REG_CTRL, {16'h0000, c});
    axr(REG_CTRL);
    chk(rd, {16'h0000, 1'b0, c[14], 1'b1, c[12:0]}, "ctrl error");
    chk(32'(starts), 32'(s0), "no start");
    $display("test bad start %0d done", mode);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    axr(REG_CTRL);
    chk(rd, {16'h0000, CTRL_RESET}, "ctrl reset");
    axr(REG_KEY);
    chk(rd, 32'h00000000, "key read");
    axr(8'h20);
    chk(32'(rr), 32'(RESP_SLVERR), "rresp");
    axw(8'h20, 32'h00000000);
    chk(32'(br), 32'(RESP_SLVERR), "bresp");
    $display("test reset done");
    bad(0, 16'hc002);
    bad(2, 16'hc002);
    bad(3, 16'hc002);
    bad(1, 16'h8002);
    bad(1, 16'hc004);
    latch(7'h00, 24'h111111);
    latch(7'h01, 24'h222222);
    latch(7'h00, 24'h0a0b0c);
    launch(OP_DWORD, 24'h012347, 24'h012344, 9'h002);
    chk(32'(mfirst), 32'h000a0b0c, "first word");
    chk(32'(mlast), 32'h00222222, "last word");
    chk(32'(mla), 32'h00012346, "last addr");
    axw(REG_CTRL, 32'h00001ff3);
    axr(REG_CTRL);
    chk(rd, 32'h00001003, "reserved bits");
    idle <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({30'h0, pd, sb}, 32'h00000002, "idle power down");
    axw(REG_CTRL, 32'h00000003);
    repeat (3) @(posedge clk_in);
    chk({30'h0, pd, sb}, 32'h00000001, "idle standby");
    idle <= 1'b0;
    launch(OP_PAGE_ERASE, 24'h0127ff, 24'h012000, 9'h000);
    for (int i = 0; i < 128; i++) latch(7'(i), 24'hffffff);
    latch(7'h7f, 24'h123456);
    launch(OP_ROW, 24'h0123ff, 24'h012300, 9'h080);
    chk(32'(mfirst), 32'h00ffffff, "row first");
    chk(32'(mlast), 32'h00123456, "row last");
    chk(32'(mla), 32'h000123fe, "row last addr");
    launch(OP_CHIP_ERASE, 24'h012bff, CHIP_ADDR, 9'h000);
    results();
  end
endmodule
`default_nettype wire
